// File: verilog/mkcd_decoder.sv
// Keyer command decoder: host byte parsing, paddle priority, settings
`timescale 1ns/1ps
// What this block does
// - Strobe paddle sampling 2000 times and pot sampling 10 times per second.
// - Paddle activity aborts serial sending and flushes the character buffer.
// - During break-in, drop host data bytes; immediate commands still execute.
// - After paddling stops, wait one word space before serial sending resumes.
// - Bytes 0x01 to 0x1f are commands; parameters follow as raw bytes.
// - Immediate commands act at once and never enter the character buffer.
// - Interface starts closed; no unsolicited bytes go out while closed.
// - Admin code 0x00 plus subcode works while closed; replies go out at once.
// - Calibrate: subcode zero, 100 ms wait, then 0xff trims the timebase.
// - Subcode 1 resets to power-up state except break-in and paddle/pot sampling; subcode 8 is reserved.
// - Subcode 2 opens the interface and answers with the revision byte.
// - Subcode 3 closes the interface; settings and paddle service stay.
// - Subcode 4 echoes the next received byte unchanged.
// - Subcode 5 returns live paddle value; thresholds 152, 104, 71 decode state.
// - Subcode 6 returns raw pot position 0 to 63, unlimited.
// - Subcode 7 returns all setup values in default-block order.
// - Subcode 9 returns the stored calibration byte.
// - Command 0x01 value 1 to 10 selects the sidetone frequency.
// - Command 0x02 sets speed 5 to 99; zero means follow the pot.
// - Command 0x03 sets weighting 10 to 90, 50 neutral.
// - Command 0x04 sets lead-in and tail, 0 to 250 in 10 ms units.
// - Command 0x05 sets pot minimum, span and full scale.
// - Pot reports to host carry 10 in the two top bits.
module mkcd_decoder
	import mkcd_pkg::*;
#(
	parameter int         FIFO_DEPTH = 8,
	parameter int         PADDLE_DIV_P = mkcd_pkg::PADDLE_DIV,
	parameter int         POT_DIV_P    = mkcd_pkg::POT_DIV,
	parameter int         CAL_WAIT_P   = mkcd_pkg::CAL_WAIT_CYC,
	parameter int         MS_CYC_P     = mkcd_pkg::CYC_PER_MS,
	parameter logic [7:0] REV_CODE     = 8'h0a
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       rx_valid_i,
	output logic [7:0]      tx_data_o,
	output logic            tx_valid_o,
	input  wire logic       tx_ready_i,
	input  wire logic [7:0] paddle_adc_i,
	input  wire logic [5:0] pot_adc_i,
	output logic            paddle_sample_o,
	output logic            pot_sample_o,
	output logic            dit_down_o,
	output logic            dah_down_o,
	input  wire logic       keying_active_i,
	output logic            break_in_o,
	output logic            send_enable_o,
	output logic            buffer_flush_o,
	output logic [7:0]      buf_data_o,
	output logic            buf_valid_o,
	output logic            host_open_o,
	output logic [3:0]      sidetone_sel_o,
	output logic [6:0]      words_per_minute_o,
	output logic [6:0]      weighting_o,
	output logic [7:0]      ptt_lead_o,
	output logic [7:0]      ptt_tail_o,
	output logic [6:0]      pot_min_speed_o,
	output logic [6:0]      pot_speed_span_o,
	output logic [6:0]      pot_full_scale_o,
	output logic [7:0]      cal_value_o,
	output logic            cal_done_o
);
	////////////////////////////////////////////////////////////////////////
	mkcd_fifo_if #(.W(8)) rq ();
	mkcd_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.port      (rq.fifo)
	);
	assign tx_data_o    = rq.out_data;
	assign tx_valid_o   = rq.out_valid;
	assign rq.out_ready = tx_ready_i;

	////////////////////////////////////////////////////////////////////////
	// Sample strobes
	logic [31:0] pad_cnt, next_pad_cnt, pot_cnt, next_pot_cnt;
	logic [7:0]  pad_val, next_pad_val;
	logic [5:0]  pot_val, next_pot_val, pot_rep, next_pot_rep;
	logic        pad_tick, pot_tick;
	assign pad_tick = (pad_cnt == 32'(PADDLE_DIV_P - 1));
	assign pot_tick = (pot_cnt == 32'(POT_DIV_P - 1));

	always_comb
	begin
		next_pad_cnt = pad_tick ? '0 : pad_cnt + 32'd1;
		next_pot_cnt = pot_tick ? '0 : pot_cnt + 32'd1;
		next_pad_val = pad_tick ? paddle_adc_i : pad_val;
		next_pot_val = pot_tick ? pot_adc_i : pot_val;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pad_cnt <= '0;
			pot_cnt <= '0;
			pad_val <= 8'hff;
			pot_val <= '0;
		end
		else
		begin
			pad_cnt <= next_pad_cnt;
			pot_cnt <= next_pot_cnt;
			pad_val <= next_pad_val;
			pot_val <= next_pot_val;
		end
	end
	assign paddle_sample_o = pad_tick;
	assign pot_sample_o    = pot_tick;

	// Paddle thresholds on the latest sample
	always_comb
	begin
		dit_down_o = 1'b0;
		dah_down_o = 1'b0;
		if (pad_val >= PAD_UP_MIN)
			dit_down_o = 1'b0;
		else if (pad_val >= PAD_DIT_MIN)
			dit_down_o = 1'b1;
		else if (pad_val >= PAD_DAH_MIN)
			dah_down_o = 1'b1;
		else
		begin
			dit_down_o = 1'b1;
			dah_down_o = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Break-in and word-space hang
	logic        paddle_act;
	logic        brk, next_brk;
	logic [31:0] hang, next_hang, word_cyc;
	logic [6:0]  eff_wpm;
	assign paddle_act = dit_down_o || dah_down_o || keying_active_i;
	// Word space is seven dits of 1200/wpm ms
	assign word_cyc = 32'(WORD_UNITS * DIT_MS_NUM) * 32'(MS_CYC_P) / {25'd0, eff_wpm};

	always_comb
	begin
		next_brk  = brk;
		next_hang = hang;
		if (paddle_act)
		begin
			next_brk  = 1'b1;
			next_hang = word_cyc;
		end
		else if (brk)
		begin
			if (hang <= 32'd1)
				next_brk = 1'b0;
			next_hang = hang - 32'd1;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			brk  <= 1'b0;
			hang <= '0;
		end
		else
		begin
			brk  <= next_brk;
			hang <= next_hang;
		end
	end
	assign break_in_o     = brk;
	assign send_enable_o  = !brk && !paddle_act;
	assign buffer_flush_o = paddle_act && !brk;

	////////////////////////////////////////////////////////////////////////
	// Command parser and settings
	mkcd_state_t st, next_st;
	logic [7:0] cmd, next_cmd;
	logic [1:0] pidx, next_pidx;
	logic [7:0] p0, next_p0, p1, next_p1;
	logic       opened, next_opened;
	logic [7:0] tone, words_per_minute, wgt, lead, tail, pmin, pspan, pfs, calv;
	logic [7:0] next_tone, next_wpm, next_wgt, next_lead, next_tail;
	logic [7:0] next_pmin, next_pspan, next_pfs, next_calv;
	logic [31:0] cal_cnt, next_cal_cnt;
	logic [3:0] vidx, next_vidx;
	logic       cdone, next_cdone;
	logic       push;
	logic [7:0] push_data;
	logic [7:0] vsel;
	logic       soft_rst;
	logic       pot_push;

	always_comb
	begin
		case (vidx)
			4'h0: vsel = tone;
			4'h1: vsel = words_per_minute;
			4'h2: vsel = wgt;
			4'h3: vsel = lead;
			4'h4: vsel = tail;
			4'h5: vsel = pmin;
			4'h6: vsel = pspan;
			default: vsel = pfs;
		endcase
	end

	always_comb
	begin
		next_st = st; next_cmd = cmd; next_pidx = pidx; next_p0 = p0; next_p1 = p1;
		next_opened = opened; next_tone = tone; next_wpm = words_per_minute; next_wgt = wgt;
		next_lead = lead; next_tail = tail; next_pmin = pmin; next_pspan = pspan;
		next_pfs = pfs; next_calv = calv; next_cal_cnt = cal_cnt; next_vidx = vidx;
		next_cdone = cdone; push = 1'b0; push_data = '0; soft_rst = 1'b0; pot_push = 1'b0;
		buf_valid_o = 1'b0;
		case (st)
			MKCD_IDLE:
			if (rx_valid_i)
			begin
				next_cmd  = rx_data_i;
				next_pidx = '0;
				if (rx_data_i == CMD_ADMIN)
					next_st = MKCD_ADMIN;
				else if (rx_data_i >= CMD_SIDETONE && rx_data_i <= CMD_POTSET)
					next_st = MKCD_PARAM;
				else if (rx_data_i > CMD_LAST && !brk)
					buf_valid_o = 1'b1;
			end
			MKCD_ADMIN:
			if (rx_valid_i)
			begin
				next_st = MKCD_IDLE;
				case (rx_data_i)
					ADM_CAL:    next_st = MKCD_CALW;
					ADM_RESET:  soft_rst = 1'b1;
					ADM_OPEN:
					begin
						next_opened = 1'b1;
						push = 1'b1;
						push_data = REV_CODE;
					end
					ADM_CLOSE:  next_opened = 1'b0;
					ADM_ECHO:   next_st = MKCD_ECHO;
					ADM_PADDLE:
					begin
						push = 1'b1;
						push_data = pad_val;
					end
					ADM_POT:
					begin
						push = 1'b1;
						push_data = {2'b00, pot_val};
					end
					ADM_VALUES:
					begin
						next_vidx = '0;
						next_st = MKCD_VALUES;
					end
					ADM_GETCAL:
					begin
						push = 1'b1;
						push_data = calv;
					end
					default:    next_st = MKCD_IDLE;
				endcase
			end
			MKCD_ECHO:
			if (rx_valid_i)
			begin
				push = 1'b1;
				push_data = rx_data_i;
				next_st = MKCD_IDLE;
			end
			MKCD_VALUES:
			if (rq.in_ready)
			begin
				push = 1'b1;
				push_data = vsel;
				next_vidx = vidx + 4'h1;
				if (vidx == N_VALUES - 4'h1)
					next_st = MKCD_IDLE;
			end
			MKCD_CALW:
			begin
				next_cal_cnt = cal_cnt + 32'd1;
				if (rx_valid_i)
				begin
					next_st = MKCD_IDLE;
					// Gap includes the edge that takes the end byte
					if (rx_data_i == CAL_END && cal_cnt + 32'd1 >= 32'(CAL_WAIT_P))
					begin
						next_calv = 8'((cal_cnt + 32'd1) / 32'(CAL_WAIT_P / 128));
						next_cdone = 1'b1;
					end
					next_cal_cnt = '0;
				end
			end
			MKCD_PARAM:
			if (rx_valid_i)
			begin
				next_pidx = pidx + 2'd1;
				next_p0 = (pidx == 2'd0) ? rx_data_i : p0;
				next_p1 = (pidx == 2'd1) ? rx_data_i : p1;
				next_st = MKCD_IDLE;
				case (cmd)
					CMD_SIDETONE:
					if (rx_data_i >= TONE_MIN && rx_data_i <= TONE_MAX)
						next_tone = rx_data_i;
					CMD_SPEED:
					if (rx_data_i == RST_WPM || (rx_data_i >= WPM_MIN && rx_data_i <= WPM_MAX))
						next_wpm = rx_data_i;
					CMD_WEIGHT:
					if (rx_data_i >= WGT_MIN && rx_data_i <= WGT_MAX)
						next_wgt = rx_data_i;
					CMD_PTT:
					if (pidx == 2'd0)
						next_st = MKCD_PARAM;
					else if (p0 <= PTT_MAX && rx_data_i <= PTT_MAX)
					begin
						next_lead = p0;
						next_tail = rx_data_i;
					end
					CMD_POTSET:
					if (pidx != 2'd2)
						next_st = MKCD_PARAM;
					else if (p0 >= WPM_MIN && 9'(p0) + 9'(p1) <= 9'(WPM_MAX)
						&& rx_data_i <= POT_RAW_MAX)
					begin
						next_pmin = p0;
						next_pspan = p1;
						next_pfs = rx_data_i;
					end
					default: next_st = MKCD_IDLE;
				endcase
			end
			default: next_st = MKCD_IDLE;
		endcase
		// Unsolicited pot change only while open
		if (!push && opened && pot_rep != pot_val && st == MKCD_IDLE)
		begin
			push = 1'b1;
			pot_push = 1'b1;
			push_data = {POT_TAG, pot_val};
		end
	end
	assign buf_data_o = rx_data_i;
	// Only a report the FIFO took counts as sent, so a dropped one retries
	assign next_pot_rep = (pot_push && rq.in_ready) ? pot_val : pot_rep;
	assign rq.in_valid = push;
	assign rq.in_data  = push_data;
	assign rq.flush    = soft_rst;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= MKCD_IDLE; cmd <= '0; pidx <= '0; p0 <= '0; p1 <= '0;
			opened <= 1'b0;
			tone <= RST_TONE; words_per_minute <= RST_WPM; wgt <= RST_WGT; lead <= RST_LEAD;
			tail <= RST_TAIL; pmin <= RST_POT_MIN; pspan <= RST_POT_SPAN;
			pfs <= RST_POT_FS; calv <= RST_CAL; cal_cnt <= '0; vidx <= '0;
			cdone <= 1'b0; pot_rep <= '0;
		end
		else if (soft_rst)
		begin
			st <= MKCD_IDLE; cmd <= '0; pidx <= '0; p0 <= '0; p1 <= '0;
			opened <= 1'b0;
			tone <= RST_TONE; words_per_minute <= RST_WPM; wgt <= RST_WGT; lead <= RST_LEAD;
			tail <= RST_TAIL; pmin <= RST_POT_MIN; pspan <= RST_POT_SPAN;
			pfs <= RST_POT_FS; calv <= RST_CAL; cal_cnt <= '0; vidx <= '0;
			cdone <= 1'b0; pot_rep <= '0;
		end
		else
		begin
			st <= next_st; cmd <= next_cmd; pidx <= next_pidx; p0 <= next_p0;
			p1 <= next_p1; opened <= next_opened; tone <= next_tone; words_per_minute <= next_wpm;
			wgt <= next_wgt; lead <= next_lead; tail <= next_tail; pmin <= next_pmin;
			pspan <= next_pspan; pfs <= next_pfs; calv <= next_calv;
			cal_cnt <= next_cal_cnt; vidx <= next_vidx; cdone <= next_cdone;
			pot_rep <= next_pot_rep;
		end
	end

	// Pot maps 0..full scale onto min..min+span when speed is zero
	logic [13:0] pot_scaled;
	assign pot_scaled = (pfs == '0) ? '0 : 14'({8'd0, pot_val} * 14'(pspan) / 14'(pfs));
	assign eff_wpm = (words_per_minute != RST_WPM) ? words_per_minute[6:0] : 7'(14'(pmin) + pot_scaled);

	assign host_open_o        = opened;
	assign sidetone_sel_o     = tone[3:0];
	assign words_per_minute_o = eff_wpm;
	assign weighting_o        = wgt[6:0];
	assign ptt_lead_o         = lead;
	assign ptt_tail_o         = tail;
	assign pot_min_speed_o    = pmin[6:0];
	assign pot_speed_span_o   = pspan[6:0];
	assign pot_full_scale_o   = pfs[6:0];
	assign cal_value_o        = calv;
	assign cal_done_o         = cdone;

	////////////////////////////////////////////////////////////////////////
	a_closed_silent: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st == MKCD_IDLE && !opened) |-> !rq.in_valid)
		else $error("unsolicited byte while closed");
	a_pot_tag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rq.in_valid && st == MKCD_IDLE) |-> rq.in_data[7:6] == POT_TAG)
		else $error("pot report lacks tag");
	a_open_reply: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st == MKCD_ADMIN && rx_valid_i && rx_data_i == ADM_OPEN)
		|-> rq.in_valid && rq.in_data == REV_CODE ##1 opened)
		else $error("open without revision reply");
	a_flush_on_paddle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(paddle_act) && !brk |-> buffer_flush_o ##1 brk)
		else $error("paddle did not flush");
	a_breakin_drop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		brk |-> !buf_valid_o)
		else $error("data buffered during break-in");
	a_speed_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(words_per_minute == RST_WPM) || (words_per_minute >= WPM_MIN && words_per_minute <= WPM_MAX))
		else $error("speed out of range");
	a_tone_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		tone >= TONE_MIN && tone <= TONE_MAX)
		else $error("sidetone out of range");
	a_echo_back: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(st == MKCD_ECHO && rx_valid_i) |-> rq.in_valid && rq.in_data == rx_data_i)
		else $error("echo byte not returned");
endmodule

// File: verilog/mkcd_pkg.sv
// Shared constants and types for the keyer command decoder
package mkcd_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned PADDLE_RATE_HZ  = 2000;
	localparam int unsigned POT_RATE_HZ     = 10;
	localparam int unsigned PADDLE_DIV      = CLK_HZ / PADDLE_RATE_HZ;
	localparam int unsigned POT_DIV         = CLK_HZ / POT_RATE_HZ;
	localparam int unsigned CAL_WAIT_MS     = 100;
	localparam int unsigned CAL_WAIT_CYC    = CLK_HZ / 1000 * CAL_WAIT_MS;
	localparam int unsigned WORD_UNITS      = 7;
	localparam int unsigned DIT_MS_NUM      = 1200;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

	localparam logic [7:0] CMD_ADMIN    = 8'h00;
	localparam logic [7:0] CMD_SIDETONE = 8'h01;
	localparam logic [7:0] CMD_SPEED    = 8'h02;
	localparam logic [7:0] CMD_WEIGHT   = 8'h03;
	localparam logic [7:0] CMD_PTT      = 8'h04;
	localparam logic [7:0] CMD_POTSET   = 8'h05;
	localparam logic [7:0] CMD_LAST     = 8'h1f;
	localparam logic [7:0] CAL_END      = 8'hff;

	localparam logic [7:0] ADM_CAL      = 8'h00;
	localparam logic [7:0] ADM_RESET    = 8'h01;
	localparam logic [7:0] ADM_OPEN     = 8'h02;
	localparam logic [7:0] ADM_CLOSE    = 8'h03;
	localparam logic [7:0] ADM_ECHO     = 8'h04;
	localparam logic [7:0] ADM_PADDLE   = 8'h05;
	localparam logic [7:0] ADM_POT      = 8'h06;
	localparam logic [7:0] ADM_VALUES   = 8'h07;
	localparam logic [7:0] ADM_RSVD     = 8'h08;
	localparam logic [7:0] ADM_GETCAL   = 8'h09;

	localparam logic [7:0] PAD_UP_MIN   = 8'h98;
	localparam logic [7:0] PAD_DIT_MIN  = 8'h68;
	localparam logic [7:0] PAD_DAH_MIN  = 8'h47;

	localparam logic [7:0] TONE_MIN     = 8'h01;
	localparam logic [7:0] TONE_MAX     = 8'h0a;
	localparam logic [7:0] WPM_MIN      = 8'h05;
	localparam logic [7:0] WPM_MAX      = 8'h63;
	localparam logic [7:0] WGT_MIN      = 8'h0a;
	localparam logic [7:0] WGT_MAX      = 8'h5a;
	localparam logic [7:0] PTT_MAX      = 8'hfa;
	localparam logic [7:0] POT_RAW_MAX  = 8'h3f;

	localparam logic [7:0] RST_TONE     = 8'h05;
	localparam logic [7:0] RST_WPM      = 8'h00;
	localparam logic [7:0] RST_WGT      = 8'h32;
	localparam logic [7:0] RST_LEAD     = 8'h00;
	localparam logic [7:0] RST_TAIL     = 8'h00;
	localparam logic [7:0] RST_POT_MIN  = 8'h05;
	localparam logic [7:0] RST_POT_SPAN = 8'h1f;
	localparam logic [7:0] RST_POT_FS   = 8'h3f;
	localparam logic [7:0] RST_CAL      = 8'h80;
	localparam logic [1:0] POT_TAG      = 2'b10;
	localparam logic [3:0] N_VALUES     = 4'h8;

	typedef enum logic [3:0] {
		MKCD_IDLE   = 4'b0000,
		MKCD_ADMIN  = 4'b0001,
		MKCD_PARAM  = 4'b0010,
		MKCD_ECHO   = 4'b0011,
		MKCD_CALW   = 4'b0100,
		MKCD_CALF   = 4'b0101,
		MKCD_VALUES = 4'b0110
	} mkcd_state_t;
endpackage

// File: verilog/mkcd_fifo_if.sv
// Handshake bundle between the decoder and its reply FIFO
`timescale 1ns/1ps
interface mkcd_fifo_if #(parameter int W = 8);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	logic         flush;
	modport producer (output in_valid, output in_data, output flush, input in_ready);
	modport fifo (input in_valid, input in_data, input flush, output in_ready,
		output out_valid, output out_data, input out_ready);
endinterface

// File: verilog/mkcd_fifo.sv
// Small synchronous FIFO with registered read data
`timescale 1ns/1ps
module mkcd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic     ref_clk_i,
	input  wire logic     rst_i,
	mkcd_fifo_if.fifo     port
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW:0]   wr_ptr;
	logic [AW:0]   rd_ptr;
	logic [AW:0]   next_wr_ptr;
	logic [AW:0]   next_rd_ptr;
	logic [W-1:0]  dout;
	logic          dvalid;
	logic          next_dvalid;
	logic          empty;
	logic          full;
	logic          pop;

	assign empty = (wr_ptr == rd_ptr);
	assign full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign port.in_ready  = !full;
	assign port.out_valid = dvalid;
	assign port.out_data  = dout;
	// Output register refills when drained or empty
	assign pop = !empty && (!dvalid || port.out_ready);

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_dvalid = dvalid;
		if (port.in_valid && !full)
			next_wr_ptr = wr_ptr + 1'b1;
		if (pop)
			next_rd_ptr = rd_ptr + 1'b1;
		if (pop)
			next_dvalid = 1'b1;
		else if (port.out_ready)
			next_dvalid = 1'b0;
		if (port.flush)
		begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_dvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			dvalid <= 1'b0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			dvalid <= next_dvalid;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (port.in_valid && !full)
			mem[wr_ptr[AW-1:0]] <= port.in_data;
		if (pop)
			dout <= mem[rd_ptr[AW-1:0]];
	end
endmodule

// File: dv/mkcd_host_model.sv
// Host serial receiver model: accepts reply bytes, can stall
`timescale 1ns/1ps
module mkcd_host_model (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	input  wire logic       stall_i,
	output logic            tx_ready_o
);
	logic [7:0] rx_q[$];
	initial
	begin
		tx_ready_o = 1'b0;
	end
	// Ready moves just after the edge so a byte is taken only where both were high
	always @(posedge ref_clk_i)
	begin
		if (!rst_i && tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
			rx_q.push_back(tx_data_i);
		#2 tx_ready_o <= !rst_i && (!stall_i || ($urandom_range(0, 3) == 0));
	end
endmodule

// File: dv/morse_keyer_command_decoder_tb.sv
// Self-checking bench for the keyer command decoder
`timescale 1ns/1ps
module morse_keyer_command_decoder_tb;
	import mkcd_pkg::*;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, rx_valid = 1'b0, keying = 1'b0, stall = 1'b0;
	logic [7:0] rx_data = 8'h00, paddle = 8'hff;
	logic [5:0] pot = 6'h00;
	logic [7:0] tx_data, buf_data, lead, tail, cal;
	logic [6:0] words_per_minute, wgt, pmin, pspan, pfs;
	logic [3:0] tone;
	logic tx_valid, tx_ready, psmp, tsmp, dit, dah, brk, send_en, flush, bvalid, hopen, cdone;
	logic [7:0] e[8];
	int miscompares = 0, check_count = 0, bcnt = 0, fcnt = 0, n;
	always #20 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i)
	begin
		bcnt += (bvalid === 1'b1);
		fcnt += (flush === 1'b1);
	end
	mkcd_decoder #(.PADDLE_DIV_P(10), .POT_DIV_P(50), .CAL_WAIT_P(128), .MS_CYC_P(1)) DUT (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.paddle_adc_i(paddle), .pot_adc_i(pot), .paddle_sample_o(psmp), .pot_sample_o(tsmp),
		.dit_down_o(dit), .dah_down_o(dah), .keying_active_i(keying), .break_in_o(brk),
		.send_enable_o(send_en), .buffer_flush_o(flush), .buf_data_o(buf_data),
		.buf_valid_o(bvalid), .host_open_o(hopen), .sidetone_sel_o(tone),
		.words_per_minute_o(words_per_minute), .weighting_o(wgt), .ptt_lead_o(lead), .ptt_tail_o(tail),
		.pot_min_speed_o(pmin), .pot_speed_span_o(pspan), .pot_full_scale_o(pfs),
		.cal_value_o(cal), .cal_done_o(cdone));
	mkcd_host_model host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .stall_i(stall), .tx_ready_o(tx_ready));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		check_count++;
		if (got !== ex)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
			miscompares++;
		end
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge ref_clk_i);
		#2 rx_data = b;
		rx_valid = 1'b1;
		@(posedge ref_clk_i);
		#2 rx_valid = 1'b0;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] a, input int np, input logic [7:0] b = 0,
		input logic [7:0] d = 0);
		send(c);
		send(a);
		if (np > 1) send(b);
		if (np > 2) send(d);
		repeat (3) @(posedge ref_clk_i);
	endtask
	// Replies are waited for with a bound, never a fixed latency
	task automatic reply(input string nm, input logic [7:0] ex, input logic [7:0] msk = 8'hff);
		int w;
		for (w = 0; w < 400 && host.rx_q.size() == 0; w++) @(posedge ref_clk_i);
		if (host.rx_q.size() == 0) chk(nm, ex, 8'hxx);
		else chk(nm, ex & msk, host.rx_q.pop_front() & msk);
	endtask
	// Speed zero follows the pot: minimum plus pot share of the span
	function automatic logic [7:0] spd_exp();
		if (e[1] != RST_WPM) return e[1];
		return e[5] + 8'(16'(pot) * 16'(e[6]) / 16'(e[7]));
	endfunction
	task automatic chk_set(input string nm);
		chk({nm, " tone"}, e[0], tone);
		chk({nm, " wpm"}, spd_exp(), words_per_minute);
		chk({nm, " weight"}, e[2], wgt);
		chk({nm, " lead"}, e[3], lead);
		chk({nm, " tail"}, e[4], tail);
		chk({nm, " min"}, e[5], pmin);
		chk({nm, " span"}, e[6], pspan);
		chk({nm, " fs"}, e[7], pfs);
	endtask
	function automatic logic [1:0] pad_exp(input logic [7:0] v);
		if (v >= PAD_UP_MIN) return 2'b00;
		if (v >= PAD_DIT_MIN) return 2'b10;
		if (v >= PAD_DAH_MIN) return 2'b01;
		return 2'b11;
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(40 * 60000);
		miscompares++;
		final_report();
	end
	initial
	begin
		static logic [7:0] pv[8] = '{8'hff, 8'h98, 8'h97, 8'h68, 8'h67, 8'h47, 8'h46, 8'h00};
		void'($urandom(45));
		e = '{RST_TONE, RST_WPM, RST_WGT, RST_LEAD, RST_TAIL, RST_POT_MIN, RST_POT_SPAN, RST_POT_FS};
		repeat (12) @(posedge ref_clk_i);
		#2 rst_i = 1'b0;
		chk("open after reset", 8'h00, hopen);
		chk("cal reset", RST_CAL, cal);
		chk_set("reset");
		$display("test reset done");
		// Sample strobes over a known span
		n = 0;
		repeat (100) begin @(negedge ref_clk_i); n += (psmp === 1'b1); end
		chk("paddle strobes", 8'd10, n[7:0]);
		n = 0;
		@(posedge ref_clk_i);
		#2 pot = 6'h15;
		repeat (500) begin @(negedge ref_clk_i); n += (tsmp === 1'b1); end
		chk("pot strobes", 8'd10, n[7:0]);
		chk("closed bytes", 8'd0, host.rx_q.size());
		$display("test sampling done");
		// Diagnostics issued only while closed
		foreach (pv[i])
		begin
			@(posedge ref_clk_i);
			#2 paddle = pv[i];
			repeat (25) @(posedge ref_clk_i);
			chk("paddle decode", {6'h00, pad_exp(pv[i])}, {6'h00, dit, dah});
			cmd(CMD_ADMIN, ADM_PADDLE, 1);
			reply("paddle value", pv[i]);
		end
		@(posedge ref_clk_i);
		#2 pot = 6'h3f;
		paddle = 8'hff;
		repeat (60) @(posedge ref_clk_i);
		cmd(CMD_ADMIN, ADM_POT, 1);
		reply("pot raw", 8'h3f);
		cmd(CMD_ADMIN, ADM_GETCAL, 1);
		reply("cal byte", RST_CAL);
		cmd(CMD_ADMIN, 8'h0b, 1);
		cmd(CMD_ADMIN, ADM_RSVD, 1);
		chk("bad subcode bytes", 8'd0, host.rx_q.size());
		send(CMD_ADMIN);
		send(ADM_CAL);
		repeat (128) @(posedge ref_clk_i);
		send(CAL_END);
		repeat (3) @(posedge ref_clk_i);
		chk("cal done", 8'h01, cdone);
		// Gap of 130 cycles against 128 nominal gives 130
		chk("cal value", 8'h82, cal);
		cmd(CMD_ADMIN, ADM_ECHO, 2, 8'h05);
		reply("echo", 8'h05);
		$display("test admin done");
		// Immediate settings, random then out of range
		repeat (6)
		begin
			e[0] = $urandom_range(1, 10);
			e[1] = $urandom_range(5, 99);
			e[2] = $urandom_range(10, 90);
			e[3] = $urandom_range(0, 250);
			e[4] = $urandom_range(0, 250);
			e[5] = $urandom_range(5, 30);
			e[6] = $urandom_range(1, 31);
			e[7] = $urandom_range(1, 63);
			cmd(CMD_SIDETONE, e[0], 1);
			cmd(CMD_SPEED, e[1], 1);
			cmd(CMD_WEIGHT, e[2], 1);
			cmd(CMD_PTT, e[3], 2, e[4]);
			cmd(CMD_POTSET, e[5], 3, e[6], e[7]);
			chk_set("random");
		end
		foreach (pv[i])
		begin
			cmd(CMD_SIDETONE, (i < 4) ? 8'h00 : 8'h0b, 1);
			cmd(CMD_SPEED, (i < 4) ? 8'h04 : 8'h64, 1);
			cmd(CMD_WEIGHT, (i < 4) ? 8'h09 : 8'h5b, 1);
		end
		chk_set("out of range");
		e[1] = WPM_MAX;
		cmd(CMD_SPEED, WPM_MAX, 1);
		#2 stall = 1'b1;
		cmd(CMD_ADMIN, ADM_VALUES, 1);
		foreach (e[i]) reply("values", e[i]);
		#2 stall = 1'b0;
		$display("test settings done");
		// Text goes to the buffer, commands do not
		n = bcnt;
		cmd(8'h41, 8'h42, 1);
		chk("text bytes", 8'd2, bcnt - n);
		chk("text data", 8'h42, buf_data);
		cmd(CMD_SIDETONE, e[0], 1);
		chk("cmd not buffered", 8'd2, bcnt - n);
		// Paddle break-in
		n = fcnt;
		#2 keying = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk("break in", 8'h01, brk);
		chk("flush", 8'd1, fcnt - n);
		chk("sending off", 8'h00, send_en);
		n = bcnt;
		send(8'h43);
		e[0] = 8'h03;
		cmd(CMD_SIDETONE, 8'h03, 1);
		chk("text dropped", 8'd0, bcnt - n);
		chk("cmd in break-in", e[0], tone);
		#2 keying = 1'b0;
		repeat (8400 / WPM_MAX - 6) @(posedge ref_clk_i);
		#2 chk("word space hold", 8'h00, send_en);
		for (n = 0; n < 20 && send_en !== 1'b1; n++) #40;
		chk("send resumes", 8'h01, send_en);
		chk("word space length", 8'd6, n[7:0]);
		$display("test break-in done");
		// Open, pot report, close
		@(posedge ref_clk_i);
		#2 pot = 6'h01;
		repeat (60) @(posedge ref_clk_i);
		cmd(CMD_ADMIN, ADM_OPEN, 1);
		reply("revision", 8'h0a);
		chk("opened", 8'h01, hopen);
		reply("pot tag", {POT_TAG, 6'h01});
		cmd(CMD_ADMIN, ADM_CLOSE, 1);
		chk("closed", 8'h00, hopen);
		chk_set("after close");
		cmd(CMD_ADMIN, ADM_RESET, 1);
		e = '{RST_TONE, RST_WPM, RST_WGT, RST_LEAD, RST_TAIL, RST_POT_MIN, RST_POT_SPAN, RST_POT_FS};
		chk_set("admin reset");
		$display("test open close reset done");
		final_report();
	end
endmodule
